// ---- hdl/cpu_state_pkg.sv ----
package cpu_state_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] addr_t;

  // Fetch addresses and control-word layout
  localparam word_t RESET_VECTOR = 32'hA000_0000;
  localparam word_t FETCH_STEP = 32'h0000_0002;
  localparam word_t PRIV_VEC_OFFSET = 32'h0000_0100;
  localparam int unsigned PRIV_BIT_POS = 30;
  localparam int unsigned SLEEP_POS = 0;
  localparam int unsigned STANDBY_POS = 1;

  // Reset values
  localparam word_t SW_RESET = 32'h4000_0000;
  localparam word_t ZERO_WORD = 32'h0000_0000;

  // Register byte addresses
  localparam addr_t A_CTRL = 8'h00;
  localparam addr_t A_STATUS = 8'h04;
  localparam addr_t A_SW = 8'h08;
  localparam addr_t A_VBR = 8'h0C;
  localparam addr_t A_SAVED_CNT = 8'h10;
  localparam addr_t A_SAVED_SW = 8'h14;
  localparam addr_t A_FETCH = 8'h18;
  localparam addr_t A_BUSCTL = 8'h1C;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Processor states, Gray along reset, exception, run, bus release, power down
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_EXC = 3'h1,
    ST_RUN = 3'h3,
    ST_BUSREL = 3'h2,
    ST_PDOWN = 3'h6
  } proc_state_e;

  // Register write request from the bus slave
  typedef struct packed {
    addr_t addr;
    word_t data;
    logic [3:0] strb;
  } reg_wr_s;

  // Byte-lane merge of a register write
  function automatic word_t apply_strb(input word_t old_v, input word_t new_v, input logic [3:0] strb);
    word_t r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb
endpackage : cpu_state_pkg

// ---- hdl/reset_select.sv ----
`timescale 1ns/1ps
`default_nettype none
module reset_select
  import cpu_state_pkg::*;
(
  input wire logic ref_clk, // CPU clock
  input wire logic resetn, // Async reset, active low
  input wire logic power_on_reset_n, // Power-on reset pin
  input wire logic manual_reset_n, // Manual reset pin
  output logic por_active, // Power-on reset in force
  output logic man_active // Manual reset in force
);
  // Pin levels registered; power-on reset held asserted, manual reset held clear, through async reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      por_active <= 1'b1;
      man_active <= 1'b0;
    end else begin
      por_active <= !power_on_reset_n;
      man_active <= !manual_reset_n;
    end
  end
endmodule : reset_select
`default_nettype wire

// ---- hdl/axi_lite_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module axi_lite_slave
  import cpu_state_pkg::*;
(
  input wire logic ref_clk, // CPU clock
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic wr_req, // Write pulse to core
  output reg_wr_s wr, // Write address, data, strobes
  input wire logic [1:0] wr_resp, // Core verdict on write
  output logic rd_req, // Read pulse to core
  output addr_t rd_addr, // Read address to core
  input wire logic [31:0] rd_data, // Core read data
  input wire logic [1:0] rd_resp // Core verdict on read
);
  addr_t wr_addr_q;
  word_t wr_data_q;
  logic [3:0] wr_strb_q;

  // Captured write request, one driver per field
  assign wr = {wr_addr_q, wr_data_q, wr_strb_q};

  // Both halves held and no response pending
  assign wr_req = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_req = !s_axi_arready && !s_axi_rvalid;

  // Write address capture
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      wr_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr_q <= s_axi_awaddr;
    end else if (wr_req) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      wr_data_q <= ZERO_WORD;
      wr_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data_q <= s_axi_wdata;
      wr_strb_q <= s_axi_wstrb;
    end else if (wr_req) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_req) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read address, data and response
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      rd_addr <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ZERO_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_addr <= s_axi_araddr;
      end else if (rd_req) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_req) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : axi_lite_slave
`default_nettype wire

// ---- hdl/cpu_state_mode_control.sv ----
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cpu_state_mode_control
  import cpu_state_pkg::*;
(
  input wire logic ref_clk, // CPU clock, 40 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic power_on_reset_n, // Power-on reset pin
  input wire logic manual_reset_n, // Manual reset pin
  input wire logic bus_request, // External master wants the bus
  output logic bus_grant, // Bus released to requester
  input wire logic event_req, // Exception or interrupt request
  input wire logic [31:0] event_offset, // Vector offset of the request
  output logic event_ack, // Request taken
  input wire logic event_return, // End of exception handling
  output logic [31:0] fetch_addr, // Instruction fetch address
  output logic fetch_en, // Fetch in progress
  output logic privileged, // Privileged mode
  output logic sleep_mode, // Sleep power down
  output logic standby_mode, // Standby power down
  output logic periph_reset_n, // Peripheral reset, active low
  output logic bus_ctrl_reset_n, // Bus controller reset, active low
  output logic [2:0] state_code, // Current processor state
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  proc_state_e state, next_state;
  logic por_active, man_active, in_reset;
  logic cause_reset, priv_pend, priv_set, priv_take;
  logic wr_req, rd_req, wr_ok, priv_bit;
  logic [1:0] wr_resp, rd_resp, pd_cmd;
  reg_wr_s wr;
  addr_t rd_addr;
  word_t rd_data, pc, status_word, saved_pc, saved_sw, vbr, bus_ctrl, off_q;

  // Address classes
  function automatic logic is_mapped(input addr_t a);
    return a == A_CTRL || a == A_STATUS || a == A_SW || a == A_VBR || a == A_SAVED_CNT || a == A_SAVED_SW
      || a == A_FETCH
      || a == A_BUSCTL;
  endfunction : is_mapped

  function automatic logic is_priv(input addr_t a);
    return a == A_CTRL || a == A_SW || a == A_VBR || a == A_SAVED_SW || a == A_BUSCTL;
  endfunction : is_priv

  reset_select u_rst (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .power_on_reset_n(power_on_reset_n),
    .manual_reset_n(manual_reset_n),
    .por_active(por_active),
    .man_active(man_active)
  );

  axi_lite_slave u_bus (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_req(wr_req),
    .wr(wr),
    .wr_resp(wr_resp),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_resp(rd_resp)
  );

  // Mode and access checks
  assign in_reset = por_active || man_active;
  assign priv_bit = status_word[PRIV_BIT_POS];
  assign privileged = status_word[PRIV_BIT_POS];
  assign state_code = state;
  assign fetch_addr = pc;
  assign wr_ok = wr_req && is_mapped(wr.addr) && (priv_bit || !is_priv(wr.addr));
  assign priv_set = (wr_req && is_mapped(wr.addr) && is_priv(wr.addr) && !priv_bit)
    || (rd_req && is_mapped(rd_addr) && is_priv(rd_addr) && !priv_bit);
  assign priv_take = state == ST_RUN && next_state == ST_EXC && priv_pend;

  // Write verdict
  always_comb begin
    if (!is_mapped(wr.addr)) begin
      wr_resp = RESP_DECERR;
    end else if (is_priv(wr.addr) && !priv_bit) begin
      wr_resp = RESP_SLVERR;
    end else begin
      wr_resp = RESP_OKAY;
    end
  end

  // Read mux and verdict
  always_comb begin
    rd_data = ZERO_WORD;
    rd_resp = RESP_OKAY;
    if (!is_mapped(rd_addr)) begin
      rd_resp = RESP_DECERR;
    end else if (is_priv(rd_addr) && !priv_bit) begin
      rd_resp = RESP_SLVERR;
    end else if (rd_addr == A_CTRL) begin
      rd_data = {30'h0000_0000, pd_cmd};
    end else if (rd_addr == A_STATUS) begin
      rd_data = {28'h000_0000, priv_bit, state};
    end else if (rd_addr == A_SW) begin
      rd_data = status_word;
    end else if (rd_addr == A_VBR) begin
      rd_data = vbr;
    end else if (rd_addr == A_SAVED_CNT) begin
      rd_data = saved_pc;
    end else if (rd_addr == A_SAVED_SW) begin
      rd_data = saved_sw;
    end else if (rd_addr == A_FETCH) begin
      rd_data = pc;
    end else begin
      rd_data = bus_ctrl;
    end
  end

  // Next processor state
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET: next_state = ST_EXC;
      ST_EXC: next_state = ST_RUN;
      ST_RUN: begin
        if (priv_pend || event_req) begin
          next_state = ST_EXC;
        end else if (bus_request) begin
          next_state = ST_BUSREL;
        end else if (pd_cmd != 2'h0) begin
          next_state = ST_PDOWN;
        end
      end
      ST_BUSREL: begin
        if (!bus_request) begin
          next_state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        if (event_req) begin
          next_state = ST_EXC;
        end
      end
      default: next_state = ST_RESET;
    endcase
    if (in_reset) begin
      next_state = ST_RESET;
    end
  end

  // State register and reset cause
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RESET;
      cause_reset <= 1'b1;
    end else begin
      state <= next_state;
      cause_reset <= next_state == ST_RESET || (cause_reset && next_state == ST_EXC);
    end
  end

  // Pending privilege violation, set wins over take
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      priv_pend <= 1'b0;
    end else if (in_reset) begin
      priv_pend <= 1'b0;
    end else begin
      priv_pend <= (priv_pend && !priv_take) || priv_set;
    end
  end

  // Vector offset capture and request acknowledge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      off_q <= ZERO_WORD;
      event_ack <= 1'b0;
    end else begin
      event_ack <= next_state == ST_EXC && state != ST_RESET && !priv_take;
      if (next_state == ST_EXC && state != ST_RESET) begin
        off_q <= priv_take ? PRIV_VEC_OFFSET : event_offset;
      end
    end
  end

  // Program counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc <= RESET_VECTOR;
    end else if (state == ST_EXC) begin
      pc <= cause_reset ? RESET_VECTOR : word_t'(vbr + off_q);
    end else if (state == ST_RUN && next_state == ST_RUN) begin
      pc <= event_return ? saved_pc : word_t'(pc + FETCH_STEP);
    end
  end

  // Status word, privilege bit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status_word <= SW_RESET;
    end else if (state == ST_RESET) begin
      status_word <= SW_RESET;
    end else if (state == ST_EXC) begin
      status_word[PRIV_BIT_POS] <= 1'b1;
    end else if (state == ST_RUN && next_state == ST_RUN && event_return) begin
      status_word[PRIV_BIT_POS] <= 1'b0;
    end else if (wr_ok && wr.addr == A_SW) begin
      status_word <= apply_strb(status_word, wr.data, wr.strb);
    end
  end

  // Saved context
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      saved_pc <= ZERO_WORD;
      saved_sw <= ZERO_WORD;
    end else if (state == ST_RESET) begin
      saved_pc <= ZERO_WORD;
      saved_sw <= ZERO_WORD;
    end else if (state == ST_EXC && !cause_reset) begin
      saved_pc <= pc;
      saved_sw <= status_word;
    end
  end

  // Vector base
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vbr <= ZERO_WORD;
    end else if (state == ST_RESET) begin
      vbr <= ZERO_WORD;
    end else if (wr_ok && wr.addr == A_VBR) begin
      vbr <= apply_strb(vbr, wr.data, wr.strb);
    end
  end

  // Bus controller register, cleared by power-on reset only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_ctrl <= ZERO_WORD;
    end else if (por_active) begin
      bus_ctrl <= ZERO_WORD;
    end else if (wr_ok && wr.addr == A_BUSCTL) begin
      bus_ctrl <= apply_strb(bus_ctrl, wr.data, wr.strb);
    end
  end

  // Power-down command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pd_cmd <= 2'h0;
    end else if (state == ST_RESET || next_state == ST_PDOWN) begin
      pd_cmd <= 2'h0;
    end else if (wr_ok && wr.addr == A_CTRL && wr.strb[0]) begin
      pd_cmd <= wr.data[STANDBY_POS:SLEEP_POS];
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_grant <= 1'b0;
      fetch_en <= 1'b0;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      periph_reset_n <= 1'b0;
      bus_ctrl_reset_n <= 1'b0;
    end else begin
      bus_grant <= next_state == ST_BUSREL;
      fetch_en <= next_state == ST_RUN;
      if (state == ST_RUN && next_state == ST_PDOWN) begin
        sleep_mode <= !pd_cmd[STANDBY_POS];
        standby_mode <= pd_cmd[STANDBY_POS];
      end else if (next_state != ST_PDOWN) begin
        sleep_mode <= 1'b0;
        standby_mode <= 1'b0;
      end
      periph_reset_n <= !in_reset;
      bus_ctrl_reset_n <= !por_active;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence exc_entry_s;
    state == ST_EXC && !cause_reset;
  endsequence

  sequence run_step_s;
    state == ST_RUN && next_state == ST_RUN && !event_return;
  endsequence

  reset_override_a: assert property (in_reset |=> state == ST_RESET)
    else $error("reset pin did not force reset state");
  reset_vector_a: assert property (state == ST_RESET ##1 state == ST_EXC |=> pc == RESET_VECTOR)
    else $error("fetch after reset not at reset vector");
  context_save_a: assert property (exc_entry_s |=> saved_pc == $past(pc) && saved_sw == $past(status_word))
    else $error("context not saved on exception");
  vector_sum_a: assert property (exc_entry_s |=> pc == $past(vbr) + $past(off_q))
    else $error("handler address is not base plus offset");
  sequential_fetch_a: assert property (run_step_s |=> pc == $past(pc) + FETCH_STEP && fetch_en)
    else $error("fetch address did not step");
  power_halt_a: assert property (state == ST_PDOWN |-> !fetch_en && (sleep_mode ^ standby_mode))
    else $error("power down not halted");
  bus_release_a: assert property (state == ST_RUN && bus_request && !in_reset && !event_req && !priv_pend
    |=> bus_grant && state == ST_BUSREL)
    else $error("bus request not granted");
  md_set_a: assert property (state == ST_EXC |=> privileged)
    else $error("privilege bit not set on exception");
  md_clear_a: assert property (state == ST_RUN && next_state == ST_RUN && event_return |=> !privileged)
    else $error("privilege bit not cleared on return");
  user_refuse_a: assert property (wr_req && wr.addr == A_SW && !priv_bit && state == ST_RUN && !in_reset
    |=> status_word == $past(status_word) && s_axi_bresp == RESP_SLVERR && priv_pend)
    else $error("user write to privileged register not refused");
  five_states_a: assert property (state inside {ST_RESET, ST_EXC, ST_RUN, ST_BUSREL, ST_PDOWN})
    else $error("illegal state");
  exc_transient_a: assert property (state == ST_EXC |=> state != ST_EXC)
    else $error("exception state held too long");
  bus_ctrl_keep_a: assert property (man_active && !por_active |=> bus_ctrl == $past(bus_ctrl))
    else $error("bus controller register lost on manual reset");
endmodule : cpu_state_mode_control
`default_nettype wire

// ---- sim/reset_bus_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module reset_bus_partner (
  input wire logic ref_clk, // CPU clock
  input wire logic por_cmd, // Hold power-on reset
  input wire logic man_cmd, // Hold manual reset
  input wire logic want_bus, // Ask for the bus
  input wire logic bus_grant, // Bus released to us
  output logic power_on_reset_n, // Power-on reset pin
  output logic manual_reset_n, // Manual reset pin
  output logic bus_request // Bus request line
);
  logic [1:0] held;
  // Power-on reset pin low, other lines idle, before the first edge
  initial begin
    power_on_reset_n = 1'b0;
    manual_reset_n = 1'b1;
    bus_request = 1'b0;
    held = 2'h0;
  end
  // Pins low while commanded; a granted request stays up for a few cycles
  always @(posedge ref_clk) begin
    power_on_reset_n <= !por_cmd;
    manual_reset_n <= !man_cmd;
    held <= bus_grant ? held + 2'h1 : 2'h0;
    bus_request <= want_bus || (bus_request && bus_grant && held != 2'h3);
  end
endmodule : reset_bus_partner
`default_nettype wire

// ---- sim/test_cpu_state_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_cpu_state_mode_control;
  import cpu_state_pkg::*;
  logic ref_clk, resetn, bus_request, bus_grant, event_req, event_ack, event_return, fetch_en, privileged;
  logic sleep_mode, standby_mode, periph_reset_n, bus_ctrl_reset_n, power_on_reset_n, manual_reset_n;
  logic por_cmd, man_cmd, want_bus, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] state_code;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  addr_t s_axi_awaddr, s_axi_araddr;
  word_t event_offset, fetch_addr, s_axi_wdata, s_axi_rdata, rd;
  int error_cnt, n_tests, k, m;
  cpu_state_mode_control cpu_state_mode_control_i (.ref_clk, .resetn, .power_on_reset_n, .manual_reset_n,
    .bus_request, .bus_grant, .event_req, .event_offset, .event_ack, .event_return, .fetch_addr, .fetch_en,
    .privileged, .sleep_mode, .standby_mode, .periph_reset_n, .bus_ctrl_reset_n, .state_code,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  reset_bus_partner reset_bus_partner_i (.ref_clk, .por_cmd, .man_cmd, .want_bus, .bus_grant,
    .power_on_reset_n, .manual_reset_n, .bus_request);
  // Clock, 25 ns period
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Step past the edge so outputs are settled when looked at
  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input addr_t a, input word_t d);
    tick;
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    // Handshakes judged on the values standing at the edge
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rdt(input addr_t a);
    tick;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdt
  task wst(input logic [2:0] s);
    for (k = 0; k < 40 && state_code !== s; k++) tick;
    chk("state", state_code, s);
  endtask : wst
  task evt(input word_t off);
    event_offset <= off;
    event_req <= 1'b1;
    do tick; while (!event_ack);
    event_req <= 1'b0;
  endtask : evt
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // Watchdog
  initial begin
    #500000;
    error_cnt++;
    results;
  end
  // Main sequence
  initial begin
    resetn = 1'b0; event_req = 1'b0; event_offset = ZERO_WORD; event_return = 1'b0; por_cmd = 1'b0;
    man_cmd = 1'b0; want_bus = 1'b0; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = ZERO_WORD;
    s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; error_cnt = 0; n_tests = 0;
    repeat (2) tick;
    resetn <= 1'b1;
    wst(3'h3);
    chk("fetch", fetch_addr, RESET_VECTOR);
    chk("priv", privileged, 1);
    tick;
    chk("step", fetch_addr, RESET_VECTOR + FETCH_STEP);
    rdt(A_STATUS); chk("status", rd, 32'h0000_000b);
    rdt(8'h20); chk("decerr", rsp, RESP_DECERR);
    $display("reset exit done");
    wr(A_VBR, 32'h8000_0000);
    evt(32'h0000_0040);
    chk("exc", state_code, 3'h1);
    chk("priv", privileged, 1);
    tick;
    chk("handler", fetch_addr, 32'h8000_0040);
    rdt(A_SAVED_SW); chk("saved sw", rd, SW_RESET);
    event_return <= 1'b1; tick; event_return <= 1'b0; repeat (2) tick;
    chk("user", privileged, 0);
    rdt(A_STATUS); chk("status", rd, 32'h0000_0003);
    wr(A_SW, SW_RESET); chk("slverr", rsp, RESP_SLVERR);
    for (k = 0; k < 40 && fetch_addr !== 32'h8000_0100; k++) tick;
    chk("fault", fetch_addr, 32'h8000_0100);
    chk("priv", privileged, 1);
    rdt(A_SAVED_SW); chk("saved sw", rd, ZERO_WORD);
    $display("exception done");
    want_bus <= 1'b1;
    for (k = 0; k < 40 && bus_grant !== 1'b1; k++) tick;
    chk("busrel", state_code, 3'h2);
    want_bus <= 1'b0;
    wst(3'h3);
    for (m = 1; m < 3; m++) begin
      wr(A_CTRL, m);
      wst(3'h6);
      chk("pdmode", {standby_mode, sleep_mode}, m);
      chk("halt", fetch_en, 0);
      evt(ZERO_WORD);
      wst(3'h3);
    end
    $display("bus and power down done");
    wr(A_BUSCTL, 32'h1234_5678);
    want_bus <= 1'b1; man_cmd <= 1'b1;
    wst(3'h0);
    repeat (3) tick;
    chk("grant", bus_grant, 0);
    chk("periph", periph_reset_n, 0);
    chk("busctl rst", bus_ctrl_reset_n, 1);
    want_bus <= 1'b0; man_cmd <= 1'b0;
    wst(3'h3);
    chk("fetch", fetch_addr, RESET_VECTOR);
    rdt(A_BUSCTL); chk("busctl keep", rd, 32'h1234_5678);
    rdt(A_VBR); chk("vbr", rd, ZERO_WORD);
    por_cmd <= 1'b1;
    wst(3'h0);
    tick;
    chk("busctl rst", bus_ctrl_reset_n, 0);
    chk("periph", periph_reset_n, 0);
    por_cmd <= 1'b0;
    wst(3'h3);
    rdt(A_BUSCTL); chk("busctl clr", rd, ZERO_WORD);
    $display("resets done");
    results;
  end
endmodule : test_cpu_state_mode_control
`default_nettype wire
